// >>> hw/afs_pkg.sv
package afs_pkg;

   // Register byte offsets on the bus
   localparam logic [4:0] OFS_SYNDROME = 5'h00;
   localparam logic [4:0] OFS_FAULT_ADDR = 5'h04;
   localparam logic [4:0] OFS_RET_ADDR = 5'h08;
   localparam logic [4:0] OFS_MACH_STATE = 5'h0c;
   localparam logic [4:0] OFS_CTRL = 5'h10;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h14;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
   localparam logic [4:0] OFS_FAULT_COUNT = 5'h1c;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0] RST_IRQ = 3'h0;
   localparam logic RST_SPLIT_EN = 1'b0;

   // Control and interrupt bit positions
   localparam int CTRL_SPLIT_EN = 0;
   localparam int IRQ_ALIGN = 0;
   localparam int IRQ_SPLIT = 1;
   localparam int IRQ_PROG_ERR = 2;
   localparam int IRQ_W = 3;

   // Instruction fields, bit 0 of the encoding is the MSB of the word
   localparam int INS_OPCD_HI = 31;
   localparam int INS_OPCD_LO = 26;
   localparam int INS_XO_HI = 10;
   localparam int INS_XO_LO = 1;
   localparam logic [5:0] OPCD_INDEXED = 6'h1f;
   localparam logic [9:0] XO_LWARX = 10'h014;
   localparam logic [9:0] XO_STWCX = 10'h096;
   localparam logic [9:0] XO_ECIWX = 10'h136;
   localparam logic [9:0] XO_ECOWX = 10'h1b6;

   // Syndrome field positions (word bit numbers)
   localparam int SYN_CLR_HI = 31;
   localparam int SYN_CLR_LO = 17;
   localparam int SYN_MODE_HI = 16;
   localparam int SYN_MODE_LO = 15;
   localparam int SYN_UPD = 14;
   localparam int SYN_OP_HI = 13;
   localparam int SYN_OP_LO = 10;
   localparam int SYN_REG_HI = 9;
   localparam int SYN_REG_LO = 5;
   localparam int SYN_BASE_HI = 4;
   localparam int SYN_BASE_LO = 0;

   // Machine state bits copied on entry, all others cleared
   localparam logic [31:0] MSR_KEEP_MASK = 32'h0000_ff73;

   // Bus handshake states
   typedef enum logic {
      AFS_BUS_IDLE = 1'b0,
      AFS_BUS_ACK = 1'b1
   } afs_bus_e;

endpackage

// >>> hw/afs_core.sv
// Summary of operation
// (RULE1) Clear syndrome bits 0 to 14 on fault
// (RULE2) Indexed form: instruction bits 29-30 to 15-16
// (RULE3) Immediate form: syndrome bits 15-16 cleared
// (RULE4) Bit 17 takes instruction bit 25 or 5
// (RULE5) Bits 18-21 take instruction 21-24 or 1-4
// (RULE6) Bits 22-26 take source or target register
// (RULE7) Update forms: bits 27-31 take base register
// (RULE8) Multiple and string: bits 27-31 take base
// (RULE9) May report the equivalent other-form syndrome
// (RULE10) No counterpart: report own syndrome only
// (RULE11) Fault address gets computed effective address
// (RULE12) Handler treats reservation misalignment as error
// (RULE13) Misaligned access faults or is split
// (RULE14) Fault only without higher-priority exception pending
// (RULE15) Saved return address is faulting instruction
// (RULE16) Saved machine state clears and copies fields
// (RULE17) Registers written in the commit cycle
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
module afs_core (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ls_valid,
   input wire logic ls_misaligned,
   input wire logic ls_splittable,
   input wire logic ls_higher_prio,
   input wire logic [31:0] ls_instr,
   input wire logic [31:0] ls_effective_address,
   input wire logic [31:0] ls_instr_address,
   input wire logic [31:0] machine_state,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic exc_take,
   output logic split_req,
   output logic [31:0] saved_return_address,
   output logic [31:0] saved_machine_state,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // Instruction decode

   logic [5:0] opcd;
   logic [9:0] xo;
   logic is_indexed;
   logic is_resv_ext;

   // Primary and extended opcode fields
   assign opcd = ls_instr[afs_pkg::INS_OPCD_HI:afs_pkg::INS_OPCD_LO];
   assign xo = ls_instr[afs_pkg::INS_XO_HI:afs_pkg::INS_XO_LO];

   // Register plus register forms share one primary opcode
   assign is_indexed = (opcd == afs_pkg::OPCD_INDEXED);

   // Reservation and external-control accesses
   assign is_resv_ext = is_indexed &&
      ((xo == afs_pkg::XO_LWARX) || (xo == afs_pkg::XO_STWCX) ||
       (xo == afs_pkg::XO_ECIWX) || (xo == afs_pkg::XO_ECOWX));

   ////////////////////////////////////////////////////////////////////////
   // Fault decision

   logic split_en_ff;
   logic may_split;

   // Splitting needs software consent and a splittable access that is not a reservation or external-control access
   assign may_split = split_en_ff && ls_splittable && !is_resv_ext;

   // Take the fault only when nothing outranks it
   always_comb begin
      exc_take = 1'b0;
      split_req = 1'b0;
      if (ls_valid && ls_misaligned && !ls_higher_prio) begin // see RULE14
         if (may_split) begin
            split_req = 1'b1; // see RULE13
         end else begin
            exc_take = 1'b1; // see RULE13
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Syndrome composition

   logic [31:0] nxt_syndrome;

   // Own encoding is always reported, never the other form's
   always_comb begin
      nxt_syndrome = afs_pkg::RST_WORD; // see RULE9 see RULE10
      nxt_syndrome[afs_pkg::SYN_CLR_HI:afs_pkg::SYN_CLR_LO] = '0; // see RULE1
      if (is_indexed) begin
         nxt_syndrome[afs_pkg::SYN_MODE_HI:afs_pkg::SYN_MODE_LO] = ls_instr[2:1]; // see RULE2
         nxt_syndrome[afs_pkg::SYN_UPD] = ls_instr[6]; // see RULE4
         nxt_syndrome[afs_pkg::SYN_OP_HI:afs_pkg::SYN_OP_LO] = ls_instr[10:7]; // see RULE5
      end else begin
         nxt_syndrome[afs_pkg::SYN_MODE_HI:afs_pkg::SYN_MODE_LO] = 2'h0; // see RULE3
         nxt_syndrome[afs_pkg::SYN_UPD] = ls_instr[26]; // see RULE4
         nxt_syndrome[afs_pkg::SYN_OP_HI:afs_pkg::SYN_OP_LO] = ls_instr[30:27]; // see RULE5
      end
      // Source or target register, meaningless for block zero
      nxt_syndrome[afs_pkg::SYN_REG_HI:afs_pkg::SYN_REG_LO] = ls_instr[25:21]; // see RULE6
      // Base register serves update, multiple and string forms alike
      nxt_syndrome[afs_pkg::SYN_BASE_HI:afs_pkg::SYN_BASE_LO] = ls_instr[20:16]; // see RULE7 see RULE8
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake

   afs_pkg::afs_bus_e bus_state_ff;
   afs_pkg::afs_bus_e nxt_bus_state;
   logic bus_req;
   logic wr_fire;
   logic rd_launch;

   // Any read or write is a request
   assign bus_req = avs_read || avs_write;

   // Every access gets exactly one wait state
   always_comb begin
      nxt_bus_state = bus_state_ff;
      case (bus_state_ff)
         afs_pkg::AFS_BUS_IDLE: begin
            if (bus_req) begin
               nxt_bus_state = afs_pkg::AFS_BUS_ACK;
            end
         end
         afs_pkg::AFS_BUS_ACK: begin
            nxt_bus_state = afs_pkg::AFS_BUS_IDLE;
         end
      endcase
   end

   // Handshake state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus_state_ff <= afs_pkg::AFS_BUS_IDLE;
      end else begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   // Waitrequest drops only in the answer cycle
   assign avs_waitrequest = (bus_state_ff != afs_pkg::AFS_BUS_ACK);

   // Writes land at the end of the answer cycle, reads are fetched at its start
   assign wr_fire = (bus_state_ff == afs_pkg::AFS_BUS_ACK) && avs_write;
   assign rd_launch = (bus_state_ff == afs_pkg::AFS_BUS_IDLE) && avs_read;

   ////////////////////////////////////////////////////////////////////////
   // Register decode

   logic sel_syn;
   logic sel_far;
   logic sel_ret;
   logic sel_msr;
   logic sel_ctrl;
   logic sel_stat;
   logic sel_mask;
   logic sel_cnt;

   // One select per register offset
   always_comb begin
      sel_syn = 1'b0;
      sel_far = 1'b0;
      sel_ret = 1'b0;
      sel_msr = 1'b0;
      sel_ctrl = 1'b0;
      sel_stat = 1'b0;
      sel_mask = 1'b0;
      sel_cnt = 1'b0;
      if (avs_address == afs_pkg::OFS_SYNDROME) begin
         sel_syn = 1'b1;
      end else if (avs_address == afs_pkg::OFS_FAULT_ADDR) begin
         sel_far = 1'b1;
      end else if (avs_address == afs_pkg::OFS_RET_ADDR) begin
         sel_ret = 1'b1;
      end else if (avs_address == afs_pkg::OFS_MACH_STATE) begin
         sel_msr = 1'b1;
      end else if (avs_address == afs_pkg::OFS_CTRL) begin
         sel_ctrl = 1'b1;
      end else if (avs_address == afs_pkg::OFS_IRQ_STATUS) begin
         sel_stat = 1'b1;
      end else if (avs_address == afs_pkg::OFS_IRQ_MASK) begin
         sel_mask = 1'b1;
      end else if (avs_address == afs_pkg::OFS_FAULT_COUNT) begin
         sel_cnt = 1'b1;
      end
   end

   // Merge write data into a word under the byte enables
   function automatic logic [31:0] afs_merge(input logic [31:0] old_word, input logic [31:0] new_word,
      input logic [3:0] be);
      logic [31:0] res;
      res = old_word;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = new_word[8*b +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Fault capture registers

   logic [31:0] syndrome_ff;
   logic [31:0] fault_addr_ff;
   logic [31:0] ret_addr_ff;
   logic [31:0] mach_state_ff;

   // Syndrome is filled in the commit cycle, a fault outranks a software write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         syndrome_ff <= afs_pkg::RST_WORD;
      end else if (exc_take) begin
         syndrome_ff <= nxt_syndrome; // see RULE17
      end else if (wr_fire && sel_syn) begin
         syndrome_ff <= afs_merge(syndrome_ff, avs_writedata, avs_byteenable);
      end
   end

   // Fault address takes the computed effective address
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fault_addr_ff <= afs_pkg::RST_WORD;
      end else if (exc_take) begin
         fault_addr_ff <= ls_effective_address; // see RULE11 see RULE17
      end else if (wr_fire && sel_far) begin
         fault_addr_ff <= afs_merge(fault_addr_ff, avs_writedata, avs_byteenable);
      end
   end

   // Return address points at the faulting instruction itself
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ret_addr_ff <= afs_pkg::RST_WORD;
      end else if (exc_take) begin
         ret_addr_ff <= ls_instr_address; // see RULE15
      end else if (wr_fire && sel_ret) begin
         ret_addr_ff <= afs_merge(ret_addr_ff, avs_writedata, avs_byteenable);
      end
   end

   // Machine state keeps the copied fields and clears the rest
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mach_state_ff <= afs_pkg::RST_WORD;
      end else if (exc_take) begin
         mach_state_ff <= machine_state & afs_pkg::MSR_KEEP_MASK; // see RULE16
      end else if (wr_fire && sel_msr) begin
         mach_state_ff <= afs_merge(mach_state_ff, avs_writedata, avs_byteenable);
      end
   end

   // Saved state outputs come straight from their registers
   assign saved_return_address = ret_addr_ff;
   assign saved_machine_state = mach_state_ff;

   ////////////////////////////////////////////////////////////////////////
   // Control and interrupts

   logic [afs_pkg::IRQ_W-1:0] irq_status_ff;
   logic [afs_pkg::IRQ_W-1:0] irq_mask_ff;
   logic [afs_pkg::IRQ_W-1:0] irq_set;
   logic [afs_pkg::IRQ_W-1:0] irq_clr;
   logic [31:0] fault_count_ff;

   // Software consent for splitting misaligned accesses
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         split_en_ff <= afs_pkg::RST_SPLIT_EN;
      end else if (wr_fire && sel_ctrl && avs_byteenable[0]) begin
         split_en_ff <= avs_writedata[afs_pkg::CTRL_SPLIT_EN];
      end
   end

   // Events that raise a status bit
   always_comb begin
      irq_set = '0;
      irq_set[afs_pkg::IRQ_ALIGN] = exc_take;
      irq_set[afs_pkg::IRQ_SPLIT] = split_req;
      irq_set[afs_pkg::IRQ_PROG_ERR] = exc_take && is_resv_ext;
   end

   // Write one to clear
   always_comb begin
      irq_clr = '0;
      if (wr_fire && sel_stat && avs_byteenable[0]) begin
         irq_clr = avs_writedata[afs_pkg::IRQ_W-1:0];
      end
   end

   // Sticky status, a new event wins over a clear in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_status_ff <= afs_pkg::RST_IRQ;
      end else begin
         irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
      end
   end

   // Interrupt mask, same layout as the status
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_mask_ff <= afs_pkg::RST_IRQ;
      end else if (wr_fire && sel_mask && avs_byteenable[0]) begin
         irq_mask_ff <= avs_writedata[afs_pkg::IRQ_W-1:0];
      end
   end

   // Level interrupt while any unmasked status bit is set
   assign irq = |(irq_status_ff & irq_mask_ff);

   // Count of faults actually taken
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fault_count_ff <= afs_pkg::RST_WORD;
      end else if (exc_take) begin
         fault_count_ff <= fault_count_ff + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path

   logic [31:0] readdata_ff;
   logic [31:0] nxt_readdata;

   // Read multiplexer, unused bits read as zero
   always_comb begin
      nxt_readdata = afs_pkg::RST_WORD;
      if (sel_syn) begin
         nxt_readdata = syndrome_ff;
      end else if (sel_far) begin
         nxt_readdata = fault_addr_ff;
      end else if (sel_ret) begin
         nxt_readdata = ret_addr_ff;
      end else if (sel_msr) begin
         nxt_readdata = mach_state_ff;
      end else if (sel_ctrl) begin
         nxt_readdata[afs_pkg::CTRL_SPLIT_EN] = split_en_ff;
      end else if (sel_stat) begin
         nxt_readdata[afs_pkg::IRQ_W-1:0] = irq_status_ff;
      end else if (sel_mask) begin
         nxt_readdata[afs_pkg::IRQ_W-1:0] = irq_mask_ff;
      end else if (sel_cnt) begin
         nxt_readdata = fault_count_ff;
      end
   end

   // Read data is latched as the answer cycle begins and stands through it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readdata_ff <= afs_pkg::RST_WORD;
      end else if (rd_launch) begin
         readdata_ff <= nxt_readdata;
      end
   end

   // Read data output
   assign avs_readdata = readdata_ff;
endmodule

// >>> dv/afs_core_chk.sv
module afs_core_chk (
   input wire logic clk_sys, rst, ls_valid, ls_misaligned, ls_higher_prio, avs_write, exc_take, split_req,
   input wire logic [31:0] ls_instr_address, machine_state, saved_return_address, saved_machine_state
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_take_cause: assert property (exc_take |-> ls_valid && ls_misaligned && !ls_higher_prio) else $error("bad take");
   a_fault_acted: assert property (ls_valid && ls_misaligned && !ls_higher_prio |-> exc_take || split_req)
      else $error("fault ignored");
   a_one_action: assert property (!(exc_take && split_req)) else $error("take and split");
   a_split_cause: assert property (split_req |-> ls_valid && ls_misaligned) else $error("bad split");
   a_ret_addr: assert property (exc_take |=> saved_return_address == $past(ls_instr_address)) else $error("ret");
   a_msr_save: assert property (exc_take |=> saved_machine_state == ($past(machine_state) & 32'h0000_ff73))
      else $error("msr");
   a_ret_hold: assert property (!exc_take && !avs_write |=> $stable(saved_return_address)) else $error("ret moved");
   a_msr_hold: assert property (!exc_take && !avs_write |=> $stable(saved_machine_state)) else $error("msr moved");
endmodule
bind afs_core afs_core_chk u_chk (.clk_sys(clk_sys), .rst(rst), .ls_valid(ls_valid), .ls_misaligned(ls_misaligned),
   .ls_higher_prio(ls_higher_prio), .avs_write(avs_write), .exc_take(exc_take), .split_req(split_req),
   .ls_instr_address(ls_instr_address), .machine_state(machine_state), .saved_return_address(saved_return_address),
   .saved_machine_state(saved_machine_state));

// >>> dv/alignment_fault_syndrome_tb_top.sv
module alignment_fault_syndrome_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst = 1, ls_valid = 0, ls_misaligned = 0, ls_splittable = 0, ls_higher_prio = 0;
   logic avs_read = 0, avs_write = 0, avs_waitrequest, exc_take, split_req, irq;
   logic [31:0] ls_instr = '0, ls_effective_address = '0, ls_instr_address = '0, machine_state = '0, avs_writedata = '0;
   logic [31:0] avs_readdata, saved_return_address, saved_machine_state, rd;
   logic [31:0] ins [2] = '{32'ha4e9_0003, 32'h7ce9_5a6e};
   // Syndromes worked out by hand: update-form immediate halfword load and its indexed twin
   logic [31:0] exp_syn [2] = '{32'h0000_50e9, 32'h0001_d0e9};
   logic [4:0] avs_address = '0;
   logic [3:0] avs_byteenable = 4'hf;
   int err_count = 0, tests_run = 0;
   afs_core u_afs_core (.clk_sys, .rst, .ls_valid, .ls_misaligned, .ls_splittable, .ls_higher_prio, .ls_instr,
      .ls_effective_address, .ls_instr_address, .machine_state, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .exc_take, .split_req, .saved_return_address,
      .saved_machine_state, .irq);
   initial forever #12.5 clk_sys = ~clk_sys;
   task give_verdict;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Compare; callers return on a falling edge, so outputs have settled
   task chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One bus cycle, held until waitrequest is seen low
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= !w;
      do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 0; avs_write <= 0;
      @(negedge clk_sys);
      if (n >= 50) begin err_count++; give_verdict; end
   endtask
   // One load/store presented for a single cycle
   task fault(input logic [31:0] i, ea, input logic hp, sp);
      @(posedge clk_sys);
      ls_valid <= 1; ls_misaligned <= 1; ls_higher_prio <= hp; ls_splittable <= sp; ls_instr <= i;
      ls_effective_address <= ea; ls_instr_address <= ea ^ 32'h1000_0000; machine_state <= 32'hffff_ffff;
      @(posedge clk_sys);
      ls_valid <= 0;
      @(negedge clk_sys);
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 0;
      bus(1, afs_pkg::OFS_IRQ_MASK, 32'h1);
      // Update-form immediate load, then its indexed twin
      for (int k = 0; k < 2; k++) begin
         fault(ins[k], 32'h2003 + k, 0, 0);
         chk(saved_return_address, (32'h2003 + k) ^ 32'h1000_0000);
         chk(saved_machine_state, 32'h0000_ff73);
         bus(0, afs_pkg::OFS_SYNDROME, 0); chk(rd, exp_syn[k]);
         bus(0, afs_pkg::OFS_FAULT_ADDR, 0); chk(rd, 32'h2003 + k);
         chk({31'h0, irq}, 32'h1);
         bus(1, afs_pkg::OFS_IRQ_STATUS, 32'h7); chk({31'h0, irq}, 32'h0);
      end
      // Pending higher-priority exception leaves registers alone
      fault(ins[0], 32'h5005, 1, 0);
      bus(0, afs_pkg::OFS_FAULT_ADDR, 0); chk(rd, 32'h2004);
      chk(saved_return_address, 32'h1000_2004);
      // Misaligned reservation load: flagged for the handler as a programming error, never split
      bus(1, afs_pkg::OFS_CTRL, 32'h1);
      fault(32'h7c64_2828, 32'h3001, 0, 1);
      bus(0, afs_pkg::OFS_IRQ_STATUS, 0); chk(rd, 32'h5);
      bus(0, afs_pkg::OFS_SYNDROME, 0); chk(rd, 32'h0000_0064);
      bus(1, afs_pkg::OFS_IRQ_STATUS, 32'h7);
      // Splittable access with splitting enabled leaves the capture registers alone
      fault(ins[0], 32'h6006, 0, 1);
      bus(0, afs_pkg::OFS_IRQ_STATUS, 0); chk(rd, 32'h2);
      bus(0, afs_pkg::OFS_FAULT_ADDR, 0); chk(rd, 32'h3001);
      bus(0, afs_pkg::OFS_FAULT_COUNT, 0); chk(rd, 32'h3);
      // Software may rewrite the syndrome between faults
      bus(1, afs_pkg::OFS_SYNDROME, 32'hdead_beef);
      bus(0, afs_pkg::OFS_SYNDROME, 0); chk(rd, 32'hdead_beef);
      give_verdict;
   end
endmodule
